// ===== hw/mtio_consts.vh
// constants for the measurement trigger and parallel i/o block
`ifndef MTIO_CONSTS_VH
`define MTIO_CONSTS_VH
// register byte offsets
`define MTIO_CTRL_OFS 12'h000
`define MTIO_CMD_OFS 12'h004
`define MTIO_EOCW_OFS 12'h008
`define MTIO_DLY_OFS 12'h00C
`define MTIO_GOUT_OFS 12'h010
`define MTIO_FLAG_OFS 12'h014
`define MTIO_STAT_OFS 12'h018
// ctrl fields
`define MTIO_CTRL_CONT 0
`define MTIO_CTRL_EXTSRC 1
`define MTIO_CTRL_PULSE 2
`define MTIO_CTRL_DLYEN 3
`define MTIO_CTRL_LOCK 4
`define MTIO_CTRL_ERRASYNC 5
`define MTIO_CTRL_REMOTE 6
`define MTIO_CTRL_RST 7'h01
// cmd fields (write one pulses)
`define MTIO_CMD_ARM 0
`define MTIO_CMD_READ 1
`define MTIO_CMD_TRG 2
`define MTIO_CMD_KEY 3
`define MTIO_CMD_CLRERR 4
// timing
`define MTIO_CLK_HZ 25000000
`define MTIO_TICK_MS 1
`define MTIO_EOCW_MIN 7'h01
`define MTIO_EOCW_MAX 7'h64
`define MTIO_EOCW_RST 7'h01
`define MTIO_DLY_MAX 14'h270F
`endif

// ===== hw/mtio_top.v
// trigger sequencer and parallel i/o logic with apb register access
`include "mtio_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module mtio_top #(
    parameter integer CLK_HZ = `MTIO_CLK_HZ,
    parameter integer TICK_CYCLES = CLK_HZ / 1000 * `MTIO_TICK_MS
) (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // parallel control port inputs, active low
    input wire [4:0] ctrl_in_n,
    // measurement engine
    output reg meas_start,
    input wire meas_done,
    input wire meas_err,
    // parallel control port outputs
    output reg [9:0] general_out,
    output reg eoc_out,
    output reg err_out,
    output reg external_source_indicator
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_DLY = 2'b10;
    localparam [1:0] ST_MEAS = 2'b11;

    reg [6:0] ctrl;
    reg [6:0] eoc_width;
    reg [13:0] dly_ms;
    reg [4:0] flags;
    reg [1:0] state;
    reg read_armed;
    reg exec_err;
    reg [14:0] sync0, sync1, sync2;
    reg [4:0] in_state;
    reg [31:0] tick_cnt;
    reg tick;
    reg [13:0] ms_cnt;
    reg [6:0] eoc_cnt;
    reg next_eoc;

    wire cont = ctrl[`MTIO_CTRL_CONT];
    wire ext_src = ctrl[`MTIO_CTRL_EXTSRC];
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `MTIO_CTRL_OFS) || (a == `MTIO_CMD_OFS) ||
                (a == `MTIO_EOCW_OFS) || (a == `MTIO_DLY_OFS) ||
                (a == `MTIO_GOUT_OFS) || (a == `MTIO_FLAG_OFS) ||
                (a == `MTIO_STAT_OFS);
        end
    endfunction

    wire cmd_wr = wr & (paddr == `MTIO_CMD_OFS);
    wire cmd_arm = cmd_wr & pwdata[`MTIO_CMD_ARM];
    wire cmd_read = cmd_wr & pwdata[`MTIO_CMD_READ];
    wire cmd_trg = cmd_wr & pwdata[`MTIO_CMD_TRG];
    wire cmd_key = cmd_wr & pwdata[`MTIO_CMD_KEY];
    wire flag_rd = rd & (paddr == `MTIO_FLAG_OFS);

    // three-stage synchroniser, rise counted when stages 2 and 3 agree
    reg [4:0] low_now;
    reg [4:0] next_in_state;
    reg [4:0] edges;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync0 <= 15'h0000;
        end else begin
            sync0 <= {10'h000, ~ctrl_in_n};
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 15'h0000;
            sync2 <= 15'h0000;
            in_state <= 5'h00;
        end else begin
            sync1 <= sync0;
            sync2 <= sync1;
            in_state <= next_in_state;
        end
    end
    always @* begin
        low_now = sync1[4:0];
        next_in_state = in_state;
        edges = 5'h00;
        if (!ctrl[`MTIO_CTRL_LOCK]) begin
            next_in_state = (low_now & sync2[4:0]) |
                (in_state & (low_now | sync2[4:0]));
            edges = next_in_state & ~in_state;
        end
    end

    // trigger sources: terminal, key, trg command
    wire term_trig = edges[0];
    wire key_trig = cmd_key;
    wire any_trig = term_trig | key_trig | (cmd_trg & ~read_armed);
    wire [4:0] set_flags = edges | {4'h0, key_trig | cmd_trg};

    // edge flag word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 5'h00;
        end else begin
            // set wins over read clear
            flags <= (flags & ~(flag_rd ? flags : 5'h00)) | set_flags;
        end
    end

    // millisecond tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h00000000;
            tick <= 1'b0;
        end else if (tick_cnt >= TICK_CYCLES - 1) begin
            tick_cnt <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
            tick <= 1'b0;
        end
    end

    // sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_WAIT;
            read_armed <= 1'b0;
            ms_cnt <= 14'h0000;
            meas_start <= 1'b0;
        end else begin
            meas_start <= 1'b0;
            case (state)
            ST_IDLE: begin
                if (!cont && (cmd_arm || cmd_read)) begin
                    state <= ST_WAIT;
                    read_armed <= cmd_read;
                end
            end
            ST_WAIT: begin
                if (!ext_src || any_trig) begin
                    read_armed <= 1'b0;
                    ms_cnt <= 14'h0000;
                    if (ctrl[`MTIO_CTRL_DLYEN] && dly_ms != 14'h0000) begin
                        state <= ST_DLY;
                    end else begin
                        state <= ST_MEAS;
                        meas_start <= 1'b1;
                    end
                end
            end
            ST_DLY: begin
                if (tick) begin
                    if (ms_cnt + 14'h0001 >= dly_ms) begin
                        state <= ST_MEAS;
                        meas_start <= 1'b1;
                    end else begin
                        ms_cnt <= ms_cnt + 14'h0001;
                    end
                end
            end
            ST_MEAS: begin
                if (meas_done) begin
                    state <= cont ? ST_WAIT : ST_IDLE;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
            endcase
        end
    end

    // done output and error output
    always @* begin
        next_eoc = eoc_out;
        if (meas_start && !ctrl[`MTIO_CTRL_PULSE]) begin
            next_eoc = 1'b0;
        end else if (state == ST_MEAS && meas_done) begin
            next_eoc = 1'b1;
        end else if (ctrl[`MTIO_CTRL_PULSE] && eoc_out && tick &&
                eoc_cnt + 7'h01 >= eoc_width) begin
            next_eoc = 1'b0;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eoc_out <= 1'b0;
            eoc_cnt <= 7'h00;
            err_out <= 1'b0;
        end else begin
            eoc_out <= next_eoc;
            if (!eoc_out) begin
                eoc_cnt <= 7'h00;
            end else if (tick) begin
                eoc_cnt <= eoc_cnt + 7'h01;
            end
            if (ctrl[`MTIO_CTRL_ERRASYNC]) begin
                if (state == ST_MEAS && meas_err) begin
                    err_out <= 1'b1;
                end else if (meas_start) begin
                    err_out <= 1'b0;
                end
            end else if (state == ST_MEAS && meas_done) begin
                err_out <= meas_err;
            end else if (meas_start) begin
                err_out <= 1'b0;
            end
        end
    end

    // registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `MTIO_CTRL_RST;
            eoc_width <= `MTIO_EOCW_RST;
            dly_ms <= 14'h0000;
            general_out <= 10'h000;
            exec_err <= 1'b0;
            external_source_indicator <= 1'b0;
        end else begin
            external_source_indicator <= ext_src;
            if (cmd_arm && cont) begin
                exec_err <= 1'b1;
            end else if (cmd_wr && pwdata[`MTIO_CMD_CLRERR]) begin
                exec_err <= 1'b0;
            end
            if (wr && paddr == `MTIO_CTRL_OFS) begin
                ctrl <= pwdata[6:0];
                if (ctrl[`MTIO_CTRL_REMOTE] && !pwdata[`MTIO_CTRL_REMOTE]) begin
                    ctrl[`MTIO_CTRL_CONT] <= 1'b1;
                end
            end
            if (wr && paddr == `MTIO_EOCW_OFS) begin
                if (pwdata[6:0] < `MTIO_EOCW_MIN) begin
                    eoc_width <= `MTIO_EOCW_MIN;
                end else if (pwdata[6:0] > `MTIO_EOCW_MAX ||
                        pwdata[31:7] != 25'h0) begin
                    eoc_width <= `MTIO_EOCW_MAX;
                end else begin
                    eoc_width <= pwdata[6:0];
                end
            end
            if (wr && paddr == `MTIO_DLY_OFS) begin
                if (pwdata[13:0] > `MTIO_DLY_MAX || pwdata[31:14] != 18'h0) begin
                    dly_ms <= `MTIO_DLY_MAX;
                end else begin
                    dly_ms <= pwdata[13:0];
                end
            end
            if (wr && paddr == `MTIO_GOUT_OFS) begin
                general_out <= pwdata[9:0];
            end
        end
    end

    // apb answer, no wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped(paddr);
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                `MTIO_CTRL_OFS: prdata <= {25'h0, ctrl};
                `MTIO_EOCW_OFS: prdata <= {25'h0, eoc_width};
                `MTIO_DLY_OFS: prdata <= {18'h0, dly_ms};
                `MTIO_GOUT_OFS: prdata <= {22'h0, general_out};
                `MTIO_FLAG_OFS: prdata <= {27'h0, flags | set_flags};
                `MTIO_STAT_OFS: prdata <= {26'h0, err_out, eoc_out,
                    exec_err, read_armed, state};
                default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // mtio_top
`default_nettype wire

// ===== test/mtio_engine_model.sv
// measurement engine model answering start pulses
`timescale 1ns/100ps
`default_nettype none
module mtio_engine_model #(parameter integer DELAY = 20) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // start and completion
    input wire logic meas_start,
    input wire logic err_en,
    output logic meas_done,
    output logic meas_err
);
    int cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            meas_done <= 1'b0;
            meas_err <= 1'b0;
        end else begin
            meas_done <= (cnt == 1);
            // error only valid beside done, toggles otherwise
            meas_err <= (cnt == 1) ? err_en : !meas_err;
            cnt <= meas_start ? DELAY : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule // mtio_engine_model
`default_nettype wire

// ===== test/mtio_top_checker.sv
// assertion checker for the trigger and port block
`timescale 1ns/100ps
`default_nettype none
module mtio_top_checker #(parameter integer TICK_CYCLES = 4) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // sequencer and port
    input wire logic meas_start,
    input wire logic meas_done,
    input wire logic eoc_out,
    input wire logic err_out,
    input wire logic external_source_indicator,
    input wire logic [9:0] general_out
);
    logic [6:0] ctrl;
    logic [6:0] wid;
    int ecnt;
    wire logic wr = psel && penable && pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 7'h01;
            wid <= 7'h01;
            ecnt <= 0;
        end else begin
            if (wr && paddr == 12'h000)
                ctrl <= pwdata[6:0] | {6'h00, ctrl[6] & !pwdata[6]};
            if (wr && paddr == 12'h008)
                wid <= pwdata[6:0];
            ecnt <= (eoc_out && ctrl[2]) ? ecnt + 1 : 0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_GOUT: assert property (wr && paddr == 12'h010 |=>
        general_out == $past(pwdata[9:0])) else $error("gout wrong");
    AST_EOC_SET: assert property ($rose(eoc_out) |->
        $past(meas_done)) else $error("eoc without done");
    AST_HOLD: assert property (meas_start && !ctrl[2] |->
        ##[0:1] !eoc_out) else $error("eoc held past start");
    AST_PULSE: assert property (ctrl[2] && eoc_out |->
        ecnt <= (wid + 1) * TICK_CYCLES + 2) else $error("pulse long");
    AST_FREERUN: assert property (ctrl[0] && !ctrl[1] &&
        !ctrl[3] && meas_done |-> ##[1:3] meas_start)
        else $error("no retrigger");
    AST_IDLE: assert property (!ctrl[0] && meas_done |=>
        !meas_start [*4]) else $error("start after idle");
    AST_ERR_SYNC: assert property ($rose(err_out) && !ctrl[5] |->
        $rose(eoc_out)) else $error("err not with eoc");
    AST_IND: assert property (external_source_indicator ==
        $past(ctrl[1])) else $error("indicator wrong");
    cover property (meas_start && !ctrl[0]);
    cover property ($fell(eoc_out) && ctrl[2]);
    cover property ($rose(err_out));
endmodule // mtio_top_checker
bind mtio_top mtio_top_checker #(.TICK_CYCLES(TICK_CYCLES)) mtio_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .meas_start(meas_start), .meas_done(meas_done), .eoc_out(eoc_out),
    .err_out(err_out), .general_out(general_out),
    .external_source_indicator(external_source_indicator));
`default_nettype wire

// ===== test/mtio_top_tb.sv
// testbench for the trigger and port block
`timescale 1ns/100ps
`default_nettype none
module mtio_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [4:0] pin_n = 5'h1F;
    logic err_en = 0, se;
    wire logic [31:0] prdata;
    wire logic [9:0] general_out;
    wire logic pready, pslverr, meas_start, meas_done, meas_err;
    wire logic eoc_out, err_out, ext_ind;
    int num_errors = 0, checked = 0, cyc = 0, starts = 0, n;
    typedef struct {logic [9:0] gout; int pin; logic [4:0] flg;} mtio_row_t;
    mtio_row_t rows [6] = '{'{10'h000, 0, 5'h01}, '{10'h3FF, 1, 5'h02},
        '{10'h2AA, 2, 5'h04}, '{10'h155, 3, 5'h08}, '{10'h200, 4, 5'h10},
        '{10'h001, 0, 5'h01}};
    mtio_top #(.TICK_CYCLES(4)) mtio_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctrl_in_n(pin_n), .meas_start(meas_start),
        .meas_done(meas_done), .meas_err(meas_err),
        .general_out(general_out), .eoc_out(eoc_out), .err_out(err_out),
        .external_source_indicator(ext_ind));
    mtio_engine_model mtio_engine_model_i (.pclk(pclk), .presetn(presetn),
        .meas_start(meas_start), .err_en(err_en), .meas_done(meas_done),
        .meas_err(meas_err));
    always #20 pclk = ~pclk;
    always @(negedge pclk) begin
        starts += meas_start;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, got);
        @(negedge pclk);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input int d);
        int k;
        k = 0;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(negedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            num_errors++;
        end
        rd = prdata;
        se = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic pin(input int b);
        @(posedge pclk);
        pin_n[b] <= 1'b0;
        repeat (6) @(posedge pclk);
        pin_n[b] <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask
    task end_sim();
        $display("compares %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(12'h010, 1, rows[i].gout);
            chk("gout", rows[i].gout, general_out);
            pin(rows[i].pin);
            apb(12'h014, 0, 0);
            chk("flags", rows[i].flg, rd);
            apb(12'h014, 0, 0);
            chk("flags clr", 0, rd);
            $display("row %0d done", i);
        end
        apb(12'h0FC, 0, 0);
        chk("slverr", 1, se);
        apb(12'h004, 1, 4);
        apb(12'h014, 0, 0);
        chk("trg flag", 1, rd);
        apb(12'h004, 1, 8);
        apb(12'h014, 0, 0);
        chk("key flag", 1, rd);
        apb(12'h000, 1, 'h11);
        pin(0);
        apb(12'h014, 0, 0);
        chk("locked", 0, rd);
        apb(12'h008, 1, 3);
        apb(12'h000, 1, 5);
        repeat (30) @(posedge pclk);
        n = 0;
        while (eoc_out !== 1'b1 && n < 99) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (eoc_out === 1'b1 && n < 99) begin
            @(posedge pclk);
            n++;
        end
        chk("pulse", 1, n >= 8 && n <= 17);
        $display("flag and pulse tests done");
        err_en <= 1'b1;
        apb(12'h000, 1, 0);
        repeat (40) @(posedge pclk);
        chk("err", 1, err_out);
        apb(12'h018, 0, 0);
        chk("idle", 0, rd & 3);
        n = starts;
        apb(12'h000, 1, 2);
        pin(0);
        apb(12'h004, 1, 4);
        repeat (30) @(posedge pclk);
        chk("no start", n, starts);
        apb(12'h004, 1, 1);
        pin(0);
        repeat (30) @(posedge pclk);
        chk("one meas", n + 1, starts);
        apb(12'h018, 0, 0);
        chk("back idle", 0, rd & 3);
        apb(12'h004, 1, 2);
        apb(12'h004, 1, 4);
        repeat (30) @(posedge pclk);
        chk("trg ignored", n + 1, starts);
        apb(12'h004, 1, 8);
        repeat (30) @(posedge pclk);
        chk("key meas", n + 2, starts);
        apb(12'h000, 1, 3);
        apb(12'h004, 1, 1);
        apb(12'h018, 0, 0);
        chk("exec err", 8, rd & 8);
        $display("sequencer tests done");
        apb(12'h000, 1, 'h40);
        apb(12'h000, 1, 0);
        apb(12'h000, 0, 0);
        chk("remote", 1, rd);
        apb(12'h010, 1, 'h155);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("gout rst", 0, general_out);
        apb(12'h000, 0, 0);
        chk("ctrl rst", 1, rd);
        $display("reset tests done");
        end_sim();
    end
endmodule // mtio_top_tb
`default_nettype wire
